// ### src/frt_pkg.sv
// Package for the free-running timer counter core.
// Assumes an AXI4-Lite slave with 32-bit data and word-aligned registers.
package frt_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CNT_HI = 8'h00;
  localparam logic [7:0] ADDR_CNT_LO = 8'h04;
  localparam logic [7:0] ADDR_ALT_HI = 8'h08;
  localparam logic [7:0] ADDR_ALT_LO = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  // Counter values
  localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // Control field positions
  localparam int CTRL_CS_LSB = 0;
  localparam int CTRL_EDGE_BIT = 2;
  localparam int CTRL_OVIE_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int CTRL_W = 4;
  localparam int BYTE_W = 8;
  // Clock select encodings
  localparam logic [1:0] CS_DIV4 = 2'h0;
  localparam logic [1:0] CS_DIV2 = 2'h1;
  localparam logic [1:0] CS_DIV8 = 2'h2;
  localparam logic [1:0] CS_EXT = 2'h3;
  // Prescaler divide limits (terminal counts)
  localparam logic [2:0] PRE_TC2 = 3'h1;
  localparam logic [2:0] PRE_TC4 = 3'h3;
  localparam logic [2:0] PRE_TC8 = 3'h7;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### src/frt_timer.sv
// Free-running 16-bit timer counter core with AXI4-Lite register access.
// Assumes one clock I_CLK at 25 MHz and a synchronous active-low reset.
// Function
// - 16-bit up-counter advances on every prescaler tick, stops only while halted.
// - Primary and alternate views both read the same count.
// - Writing either low byte view forces the count to FFFCh.
// - Reset loads FFFCh, the only reload value in any mode.
// - Internal source period is 131072, 262144 or 524288 clocks.
// - Reading a high byte captures the matching low byte into a buffer.
// - Buffered low byte stays frozen until the low byte is read.
// - After a completed sequence, low byte read returns live count.
// - Wrap from FFFFh to 0000h sets the overflow flag.
// - Interrupt issues only when enabled and global mask clear; else pending.
// - Flag clears by status read while set, then primary low access.
// - Alternate low byte access never clears the overflow flag.
// - Counter keeps running in wait state.
// - Halt freezes the count; reset restarts from reset count.
// - Both clock select bits one selects the external clock pin.
// - Edge select bit picks rising or falling external edges.
// - External clock updates are synchronised to the internal clock.
// - An unbonded timer input reads as logic one.
`timescale 1ns/1ps
`default_nettype none

module frt_timer #(
  parameter int CNT_W = 16,
  parameter bit EXT_PIN_BONDED = 1'b1
) (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_HALT,
  input wire logic I_WAIT,
  input wire logic I_GLOBAL_IRQ_MASK,
  input wire logic I_EXT_CLK,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic O_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helper
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == frt_pkg::ADDR_CNT_HI) || (a == frt_pkg::ADDR_CNT_LO) ||
                (a == frt_pkg::ADDR_ALT_HI) || (a == frt_pkg::ADDR_ALT_LO) ||
                (a == frt_pkg::ADDR_STATUS) || (a == frt_pkg::ADDR_CTRL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [2:0] pre_reg;
  logic [2:0] pre_next;
  logic [3:0] ctrl_reg;
  logic ovf_reg;
  logic ovf_next;
  logic ovf_armed_reg;
  logic [7:0] lo_buf_reg;
  logic lo_held_reg;
  logic [2:0] ext_sync_reg;
  logic ext_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel state
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  wire aw_fire = I_AWVALID && O_AWREADY;
  wire w_fire = I_WVALID && O_WREADY;
  wire wr_do = aw_got_reg && w_got_reg && !O_BVALID;
  wire wr_lo0 = w_strb_reg[0];
  wire wr_cnt_lo = wr_do && (aw_addr_reg == frt_pkg::ADDR_CNT_LO) && wr_lo0;
  wire wr_alt_lo = wr_do && (aw_addr_reg == frt_pkg::ADDR_ALT_LO) && wr_lo0;
  wire wr_ctrl = wr_do && (aw_addr_reg == frt_pkg::ADDR_CTRL) && wr_lo0;

  // Read channel decode
  wire rd_do = I_ARVALID && O_ARREADY;
  wire rd_cnt_hi = rd_do && (I_ARADDR == frt_pkg::ADDR_CNT_HI);
  wire rd_alt_hi = rd_do && (I_ARADDR == frt_pkg::ADDR_ALT_HI);
  wire rd_cnt_lo = rd_do && (I_ARADDR == frt_pkg::ADDR_CNT_LO);
  wire rd_alt_lo = rd_do && (I_ARADDR == frt_pkg::ADDR_ALT_LO);
  wire rd_status = rd_do && (I_ARADDR == frt_pkg::ADDR_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Tick generation
  wire [1:0] cs = ctrl_reg[frt_pkg::CTRL_CS_LSB +: 2];
  wire edge_rise = ctrl_reg[frt_pkg::CTRL_EDGE_BIT];
  wire ovie = ctrl_reg[frt_pkg::CTRL_OVIE_BIT];
  wire ext_level = EXT_PIN_BONDED ? I_EXT_CLK : 1'b1;
  wire ext_stable = (ext_sync_reg[1] == ext_sync_reg[2]);
  wire ext_new = ext_sync_reg[2] != ext_prev_reg;
  wire ext_edge = ext_stable && ext_new &&
                  (ext_sync_reg[2] == edge_rise);
  wire [2:0] pre_tc = (cs == frt_pkg::CS_DIV2) ? frt_pkg::PRE_TC2 :
                      (cs == frt_pkg::CS_DIV8) ? frt_pkg::PRE_TC8 :
                      frt_pkg::PRE_TC4;
  wire pre_tick = (pre_reg == pre_tc);
  wire tick = !I_HALT &&
              ((cs == frt_pkg::CS_EXT) ? ext_edge : pre_tick);
  wire wrap = tick && (count_reg == frt_pkg::CNT_MAX[CNT_W-1:0]);

  assign pre_next = (I_HALT || cs == frt_pkg::CS_EXT || pre_tick) ? 3'h0 :
                    (pre_reg + 3'h1);
  assign count_next = (wr_cnt_lo || wr_alt_lo) ? frt_pkg::CNT_RELOAD[CNT_W-1:0] :
                      tick ? (count_reg + {{(CNT_W-1){1'b0}}, 1'b1}) :
                      count_reg;
  wire cnt_lo_access = rd_cnt_lo || wr_cnt_lo;
  wire ovf_clear = ovf_armed_reg && cnt_lo_access;
  assign ovf_next = wrap ? 1'b1 : (ovf_clear ? 1'b0 : ovf_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser, three stages
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      ext_sync_reg <= 3'h7;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_level};
    end
  end

  // Last settled pin level
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      ext_prev_reg <= 1'b1;
    end else if (ext_stable) begin
      ext_prev_reg <= ext_sync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      pre_reg <= 3'h0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // Counter
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      count_reg <= frt_pkg::CNT_RELOAD[CNT_W-1:0];
    end else begin
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flag
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_next;
    end
  end

  // Two-step clear arm
  wire arm_set = rd_status && ovf_reg;
  wire arm_drop = ovf_clear || !ovf_reg;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      ovf_armed_reg <= 1'b0;
    end else if (arm_set) begin
      ovf_armed_reg <= 1'b1;
    end else if (arm_drop) begin
      ovf_armed_reg <= 1'b0;
    end
  end

  // Control
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      ctrl_reg <= frt_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= w_data_reg[frt_pkg::CTRL_W-1:0];
    end
  end

  // Interrupt request
  wire irq_next = ovf_next && ovie && !I_GLOBAL_IRQ_MASK;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low byte buffering for 16-bit reads
  wire lo_rd = rd_cnt_lo || rd_alt_lo;
  wire hi_rd = rd_cnt_hi || rd_alt_hi;
  wire lo_capture = hi_rd && !lo_held_reg;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      lo_buf_reg <= 8'h00;
    end else if (lo_capture) begin
      lo_buf_reg <= count_reg[frt_pkg::BYTE_W-1:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      lo_held_reg <= 1'b0;
    end else if (lo_rd) begin
      lo_held_reg <= 1'b0;
    end else if (lo_capture) begin
      lo_held_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data select
  wire sel_hi = (I_ARADDR == frt_pkg::ADDR_CNT_HI) ||
                (I_ARADDR == frt_pkg::ADDR_ALT_HI);
  wire sel_lo = (I_ARADDR == frt_pkg::ADDR_CNT_LO) ||
                (I_ARADDR == frt_pkg::ADDR_ALT_LO);
  wire sel_status = (I_ARADDR == frt_pkg::ADDR_STATUS);
  wire sel_ctrl = (I_ARADDR == frt_pkg::ADDR_CTRL);
  wire [7:0] hi_byte = count_reg[CNT_W-1 -: frt_pkg::BYTE_W];
  wire [7:0] live_lo = count_reg[frt_pkg::BYTE_W-1:0];
  wire [7:0] lo_byte = lo_held_reg ? lo_buf_reg : live_lo;
  wire [7:0] status_byte = {7'h00, ovf_reg};
  wire [7:0] ctrl_byte = {4'h0, ctrl_reg};
  wire [7:0] rd_byte = sel_hi ? hi_byte :
                       sel_lo ? lo_byte :
                       sel_status ? status_byte :
                       sel_ctrl ? ctrl_byte :
                       8'h00;
  logic [31:0] rd_data;
  assign rd_data = {24'h00_0000, rd_byte};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= frt_pkg::RESP_OKAY;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      O_AWREADY <= !aw_got_reg && !aw_fire && !O_BVALID;
      O_WREADY <= !w_got_reg && !w_fire && !O_BVALID;
      if (aw_fire) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= I_AWADDR;
      end
      if (w_fire) begin
        w_got_reg <= 1'b1;
        w_data_reg <= I_WDATA;
        w_strb_reg <= I_WSTRB;
      end
      if (wr_do) begin
        O_BVALID <= 1'b1;
        O_BRESP <= is_mapped(aw_addr_reg) ? frt_pkg::RESP_OKAY : frt_pkg::RESP_SLVERR;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= frt_pkg::RESP_OKAY;
    end else begin
      O_ARREADY <= !O_RVALID && !rd_do;
      if (rd_do) begin
        O_RVALID <= 1'b1;
        O_RDATA <= rd_data;
        O_RRESP <= is_mapped(I_ARADDR) ? frt_pkg::RESP_OKAY : frt_pkg::RESP_SLVERR;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### verif/frt_timer_properties.sv
// Port-level assertions for the timer core.
// Assumes binding onto frt_timer; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module frt_timer_properties (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_GLOBAL_IRQ_MASK,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0] O_RRESP,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  AST_W_ANSWER: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
    |-> ##[1:3] O_BVALID) else $error("write answer missing");
  AST_R_ANSWER: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer missing");
  AST_B_HOLD: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  AST_R_HOLD: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  AST_R_SINGLE: assert property (O_RVALID |-> !O_ARREADY) else $error("second read taken");
  AST_ERR_ZERO: assert property (O_RVALID && O_RRESP == frt_pkg::RESP_SLVERR |-> O_RDATA == 32'h0)
    else $error("error read data not zero");
  AST_IRQ_MASKED: assert property ($past(I_GLOBAL_IRQ_MASK) |-> !O_IRQ)
    else $error("irq while masked");
  AST_IRQ_ROSE: assert property ($rose(O_IRQ) |-> !$past(I_GLOBAL_IRQ_MASK))
    else $error("irq rose under mask");
  AST_RESET_IDLE: assert property (disable iff (1'b0) !I_RST_B |=> !O_BVALID && !O_RVALID && !O_IRQ)
    else $error("outputs active after reset");
endmodule
bind frt_timer frt_timer_properties u_props (.*);
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the timer core over AXI4-Lite.
// Assumes a 25 MHz clock and byte results in the low data bits.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic I_CLK = 0, I_RST_B = 0, I_HALT = 1, I_WAIT = 0, I_GLOBAL_IRQ_MASK = 1, I_EXT_CLK = 0;
  logic [7:0] I_AWADDR = 0, I_ARADDR = 0, l0;
  logic I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0, I_ARVALID = 0, I_RREADY = 0;
  logic [31:0] I_WDATA = 0, O_RDATA, d;
  logic [3:0] I_WSTRB = 4'hF;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_IRQ;
  logic [1:0] O_BRESP, O_RRESP, r;
  int failures = 0, n_checks = 0;
  always #20 I_CLK = ~I_CLK;
  frt_timer u_dut (.*);
  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge I_CLK);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge I_CLK);
    I_AWADDR <= a; I_WDATA <= v; I_AWVALID <= 1; I_WVALID <= 1;
    while (!(aw && w)) begin
      @(posedge I_CLK);
      if (O_AWREADY && I_AWVALID) begin aw = 1; I_AWVALID <= 0; end
      if (O_WREADY && I_WVALID) begin w = 1; I_WVALID <= 0; end
    end
    I_BREADY <= 1;
    do @(posedge I_CLK); while (O_BVALID !== 1'b1);
    I_BREADY <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge I_CLK);
    I_ARADDR <= a; I_ARVALID <= 1; I_RREADY <= 1;
    do begin
      @(posedge I_CLK);
      if (O_ARREADY) I_ARVALID <= 0;
    end while (O_RVALID !== 1'b1);
    d = O_RDATA; r = O_RRESP; I_RREADY <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, d);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    failures++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] cs_t [3];
    cs_t = '{frt_pkg::CS_DIV2, frt_pkg::CS_DIV4, frt_pkg::CS_DIV8};
    cyc(2);
    I_RST_B <= 1;
    // Reset count, both views, halted
    rdc(frt_pkg::ADDR_CNT_HI, 32'hFF, "cnt_hi");
    rdc(frt_pkg::ADDR_CNT_LO, 32'hFC, "cnt_lo");
    rdc(frt_pkg::ADDR_ALT_HI, 32'hFF, "alt_hi");
    rdc(frt_pkg::ADDR_ALT_LO, 32'hFC, "alt_lo");
    rdc(frt_pkg::ADDR_STATUS, 32'h0, "status");
    rd(8'h18);
    chk("unmapped_resp", {30'h0, frt_pkg::RESP_SLVERR}, {30'h0, r});
    chk("unmapped_data", 32'h0, d);
    $display("reset test done");
    // Prescaler rates, wait state active
    I_WAIT <= 1;
    for (int i = 0; i < 3; i++) begin
      wr(frt_pkg::ADDR_CTRL, {30'h0, cs_t[i]});
      wr(frt_pkg::ADDR_CNT_LO, 32'h0);
      I_HALT <= 0;
      cyc(48);
      I_HALT <= 1;
      rd(frt_pkg::ADDR_CNT_LO);
      l0 = d[7:0] - 8'hFC;
      chk("rate", 32'h1, {31'h0, (l0 >= 48 / (2 << i) - 1) && (l0 <= 48 / (2 << i) + 1)});
    end
    $display("rate test done");
    // Low byte buffered across repeated high reads
    rd(frt_pkg::ADDR_ALT_LO);
    l0 = d[7:0];
    rd(frt_pkg::ADDR_ALT_HI);
    I_HALT <= 0;
    cyc(40);
    I_HALT <= 1;
    rd(frt_pkg::ADDR_ALT_HI);
    rdc(frt_pkg::ADDR_ALT_LO, {24'h0, l0}, "buffered");
    rd(frt_pkg::ADDR_ALT_LO);
    chk("live", 32'h1, {31'h0, d[7:0] != l0});
    $display("buffer test done");
    // Overflow flag, interrupt and two-step clear
    rd(frt_pkg::ADDR_STATUS);
    rd(frt_pkg::ADDR_CNT_LO);
    rdc(frt_pkg::ADDR_STATUS, 32'h0, "pre_clear");
    wr(frt_pkg::ADDR_CTRL, 32'h9);
    wr(frt_pkg::ADDR_CNT_LO, 32'h0);
    I_HALT <= 0;
    cyc(20);
    I_HALT <= 1;
    rdc(frt_pkg::ADDR_STATUS, 32'h1, "ovf");
    chk("irq_masked", 32'h0, {31'h0, O_IRQ});
    I_GLOBAL_IRQ_MASK <= 0;
    cyc(3);
    chk("irq", 32'h1, {31'h0, O_IRQ});
    rd(frt_pkg::ADDR_ALT_LO);
    rdc(frt_pkg::ADDR_STATUS, 32'h1, "alt_keeps");
    rd(frt_pkg::ADDR_CNT_LO);
    rdc(frt_pkg::ADDR_STATUS, 32'h0, "cleared");
    cyc(3);
    chk("irq_off", 32'h0, {31'h0, O_IRQ});
    $display("overflow test done");
    // External pin, rising then falling edges, 5 active of 9 toggles
    for (int e = 1; e >= 0; e--) begin
      wr(frt_pkg::ADDR_CTRL, (e == 1) ? 32'h7 : 32'h3);
      wr(frt_pkg::ADDR_CNT_LO, 32'h0);
      I_HALT <= 0;
      repeat (9) begin
        I_EXT_CLK <= ~I_EXT_CLK;
        cyc(6);
      end
      cyc(6);
      I_HALT <= 1;
      rdc(frt_pkg::ADDR_CNT_LO, 32'h01, "ext");
    end
    $display("external clock test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
